// >>> metering_channel_control.sv
`timescale 1ns/1ps
// Notes on behaviour
// (RQ1) Every reset source restores register defaults
// (RQ2) Block bit stops engine result writes
// (RQ3) Phase compensation on both current pairs
// (RQ4) Swap bit exchanges current inputs A/B
// (RQ5) Calc enable runs power, RMS, M path
// (RQ6) M input off feeds zeros
// (RQ7) Current two input off feeds zeros
// (RQ8) Current one input off feeds zeros
// (RQ9) Voltage input off feeds zeros
// (RQ10) Current one gain: signed power of two
// (RQ11) Voltage gain: signed power of two
// (RQ12) Quarter bit cuts voltage gain by four
// (RQ13) Exponents six, seven clamp to five
module metering_channel_control #(
    parameter int SW    = metering_ctrl_pkg::SAMPLE_W,
    parameter int DEPTH = metering_ctrl_pkg::FIFO_DEPTH
) (
    input  wire logic                    core_clk,
    input  wire logic                    rst,
    // APB slave
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [metering_ctrl_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]             pwdata,
    output logic [31:0]                  prdata,
    output logic                         pready,
    output logic                         pslverr,
    // Converter samples, one set per handshake
    input  wire logic signed [SW-1:0]    voltageSample,
    input  wire logic signed [SW-1:0]    currentASample,
    input  wire logic signed [SW-1:0]    currentBSample,
    input  wire logic signed [SW-1:0]    multiSample,
    input  wire logic                    sampleValid,
    output logic                         sampleReady,
    // Conditioned samples toward the metering engines
    output logic signed [SW+5:0]         voltageOut,
    output logic signed [SW+5:0]         currentOneOut,
    output logic signed [SW+5:0]         currentTwoOut,
    output logic signed [SW+5:0]         multiOut,
    output logic                         outValid,
    input  wire logic                    outReady,
    // Engine controls
    output logic                         phaseCompVoltCurOne,
    output logic                         phaseCompVoltCurTwo,
    output logic                         calcRun,
    input  wire logic                    engineResultWrite,
    output logic                         resultWriteEnable
);
    localparam int OW = SW + metering_ctrl_pkg::GAIN_HEADROOM;
    localparam int FW = 4 * OW;

    if (SW < 2) begin : g_chk
        $error("sample width too small");
    end

    typedef struct packed {
        logic [7:0]          chanCtrl;
        logic [7:0]          gainCtrl;
        logic                voltGainQuarter;
        logic signed [OW-1:0] stVolt;
        logic signed [OW-1:0] stCurOne;
        logic signed [OW-1:0] stCurTwo;
        logic signed [OW-1:0] stMulti;
        logic                stValid;
        logic [31:0]         rdData;
    } ctrl_state_s;

    ctrl_state_s st;
    ctrl_state_s next_st;

    logic                 apbAccess;
    logic                 hitChan;
    logic                 hitGain;
    logic                 hitThird;
    logic                 hitStatus;
    logic signed [SW-1:0] curOneIn;
    logic signed [SW-1:0] curTwoIn;
    logic signed [SW-1:0] voltIn;
    logic signed [SW-1:0] multiIn;
    logic signed [OW-1:0] voltScaled;
    logic signed [OW-1:0] curOneScaled;
    logic                 fifoInReady;
    logic                 advance;
    logic [FW-1:0]        fifoOut;
    logic [$clog2(DEPTH):0] fifoLevel;

    assign apbAccess = psel && penable;
    assign hitChan   = (paddr == metering_ctrl_pkg::byteAddr(metering_ctrl_pkg::CH_ENABLE_CTRL_IDX));
    assign hitGain   = (paddr == metering_ctrl_pkg::byteAddr(metering_ctrl_pkg::GAIN_CTRL_IDX));
    assign hitThird  = (paddr == metering_ctrl_pkg::byteAddr(metering_ctrl_pkg::THIRD_CTRL_IDX));
    assign hitStatus = (paddr == metering_ctrl_pkg::byteAddr(metering_ctrl_pkg::FIFO_STATUS_IDX));

    // Zero-wait slave; error only on an unmapped address
    assign pready  = 1'b1;
    assign pslverr = apbAccess && !(hitChan || hitGain || hitThird || hitStatus);
    assign prdata  = st.rdData;

    always_comb begin
        // Swap applies before gating, so each enable guards a channel, not a pin
        curOneIn = st.chanCtrl[metering_ctrl_pkg::CURRENT_SWAP_BIT]
                 ? currentBSample : currentASample; // RQ4
        curTwoIn = st.chanCtrl[metering_ctrl_pkg::CURRENT_SWAP_BIT]
                 ? currentASample : currentBSample; // RQ4
        if (!st.chanCtrl[metering_ctrl_pkg::CURRENT_ONE_INPUT_ENABLE_BIT]) begin
            curOneIn = '0; // RQ8
        end
        if (!st.chanCtrl[metering_ctrl_pkg::CURRENT_TWO_INPUT_ENABLE_BIT]) begin
            curTwoIn = '0; // RQ7
        end
        voltIn = st.chanCtrl[metering_ctrl_pkg::VOLTAGE_INPUT_ENABLE_BIT]
               ? voltageSample : '0; // RQ9
        multiIn = st.chanCtrl[metering_ctrl_pkg::MULTI_INPUT_ENABLE_BIT]
                ? multiSample : '0; // RQ6
        // M processing is part of the calculation engine
        if (!st.chanCtrl[metering_ctrl_pkg::CALC_ENABLE_BIT]) begin
            multiIn = '0; // RQ5
        end
    end

    gain_scaler #(
        .SW (SW),
        .OW (OW)
    ) u_volt_gain (
        .sampleIn     (voltIn),
        .gainExp      (st.gainCtrl[metering_ctrl_pkg::VOLTAGE_GAIN_EXP_LSB +:
                                   metering_ctrl_pkg::GAIN_EXP_W]),
        .gainNegative (st.gainCtrl[metering_ctrl_pkg::VOLTAGE_GAIN_SIGN_BIT]),
        .quarterGain  (st.voltGainQuarter),
        .sampleOut    (voltScaled)
    ); // RQ11 RQ12

    gain_scaler #(
        .SW (SW),
        .OW (OW)
    ) u_cur_one_gain (
        .sampleIn     (curOneIn),
        .gainExp      (st.gainCtrl[metering_ctrl_pkg::CURRENT_ONE_GAIN_EXP_LSB +:
                                   metering_ctrl_pkg::GAIN_EXP_W]),
        .gainNegative (st.gainCtrl[metering_ctrl_pkg::CURRENT_ONE_GAIN_SIGN_BIT]),
        .quarterGain  (1'b0),
        .sampleOut    (curOneScaled)
    ); // RQ10

    // One pipeline stage; stalls when the FIFO is full
    assign advance     = !st.stValid || fifoInReady;
    assign sampleReady = advance;

    always_comb begin
        next_st = st;
        if (apbAccess && pwrite) begin
            if (hitChan) begin
                next_st.chanCtrl = pwdata[7:0];
            end
            if (hitGain) begin
                next_st.gainCtrl = pwdata[7:0];
            end
            if (hitThird) begin
                next_st.voltGainQuarter = pwdata[metering_ctrl_pkg::VOLTAGE_GAIN_QUARTER_BIT];
            end
        end
        // Read data is captured in the setup cycle, ready at the access edge
        next_st.rdData = '0;
        if (psel && !penable && !pwrite) begin
            if (hitChan) begin
                next_st.rdData = {24'h000000, st.chanCtrl};
            end
            if (hitGain) begin
                next_st.rdData = {24'h000000, st.gainCtrl};
            end
            if (hitThird) begin
                next_st.rdData[metering_ctrl_pkg::VOLTAGE_GAIN_QUARTER_BIT] = st.voltGainQuarter;
            end
            if (hitStatus) begin
                next_st.rdData = 32'(fifoLevel);
            end
        end
        if (advance) begin
            next_st.stValid = sampleValid;
            if (sampleValid) begin
                next_st.stVolt   = voltScaled;
                next_st.stCurOne = curOneScaled;
                next_st.stCurTwo = OW'(curTwoIn);
                next_st.stMulti  = OW'(multiIn);
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            // Reset input is the OR of every chip reset source
            st                 <= '0;
            st.chanCtrl        <= metering_ctrl_pkg::CH_ENABLE_CTRL_RST; // RQ1
            st.gainCtrl        <= metering_ctrl_pkg::GAIN_CTRL_RST; // RQ1
            st.voltGainQuarter <= metering_ctrl_pkg::GAIN_QUARTER_RST; // RQ1
        end else begin
            st <= next_st;
        end
    end

    sample_fifo #(
        .WIDTH (FW),
        .DEPTH (DEPTH)
    ) u_fifo (
        .core_clk (core_clk),
        .rst      (rst),
        .inData   ({st.stVolt, st.stCurOne, st.stCurTwo, st.stMulti}),
        .inValid  (st.stValid),
        .inReady  (fifoInReady),
        .outData  (fifoOut),
        .outValid (outValid),
        .outReady (outReady),
        .level    (fifoLevel)
    );

    assign {voltageOut, currentOneOut, currentTwoOut, multiOut} = fifoOut;

    assign phaseCompVoltCurOne = st.chanCtrl[metering_ctrl_pkg::PHASE_COMP_ENABLE_BIT]; // RQ3
    assign phaseCompVoltCurTwo = st.chanCtrl[metering_ctrl_pkg::PHASE_COMP_ENABLE_BIT]; // RQ3
    assign calcRun             = st.chanCtrl[metering_ctrl_pkg::CALC_ENABLE_BIT]; // RQ5
    // Test-only path: engines keep running but cannot store results
    assign resultWriteEnable   = engineResultWrite
                               && st.chanCtrl[metering_ctrl_pkg::CALC_ENABLE_BIT]
                               && !st.chanCtrl[metering_ctrl_pkg::RESULT_WRITE_BLOCK_BIT]; // RQ2
endmodule // metering_channel_control

// >>> metering_ctrl_pkg.sv
package metering_ctrl_pkg;
    // Register indices; byte address on the bus is four times the index
    localparam logic [15:0] CH_ENABLE_CTRL_IDX  = 16'h2878;
    localparam logic [15:0] GAIN_CTRL_IDX       = 16'h2879;
    localparam logic [15:0] THIRD_CTRL_IDX      = 16'h287A;
    localparam logic [15:0] FIFO_STATUS_IDX     = 16'h28A0;
    localparam int          ADDR_W              = 18;

    localparam logic [7:0]  CH_ENABLE_CTRL_RST  = 8'h00;
    localparam logic [7:0]  GAIN_CTRL_RST       = 8'h00;
    localparam logic        GAIN_QUARTER_RST    = 1'b0;

    // Channel enable control fields
    localparam int RESULT_WRITE_BLOCK_BIT       = 7;
    localparam int PHASE_COMP_ENABLE_BIT        = 6;
    localparam int CURRENT_SWAP_BIT             = 5;
    localparam int CALC_ENABLE_BIT              = 4;
    localparam int MULTI_INPUT_ENABLE_BIT       = 3;
    localparam int CURRENT_TWO_INPUT_ENABLE_BIT = 2;
    localparam int CURRENT_ONE_INPUT_ENABLE_BIT = 1;
    localparam int VOLTAGE_INPUT_ENABLE_BIT     = 0;

    // Voltage and current gain control fields
    localparam int CURRENT_ONE_GAIN_SIGN_BIT    = 7;
    localparam int CURRENT_ONE_GAIN_EXP_LSB     = 4;
    localparam int VOLTAGE_GAIN_SIGN_BIT        = 3;
    localparam int VOLTAGE_GAIN_EXP_LSB         = 0;
    localparam int GAIN_EXP_W                   = 3;

    // Third control register: only the voltage quarter-gain bit lives here
    localparam int VOLTAGE_GAIN_QUARTER_BIT     = 5;

    localparam logic [2:0]  GAIN_EXP_MAX        = 3'h5;
    localparam int          QUARTER_SHIFT       = 2;
    localparam int          GAIN_HEADROOM       = 6;
    localparam int          SAMPLE_W            = 24;
    localparam int          FIFO_DEPTH          = 16;

    function automatic logic [ADDR_W-1:0] byteAddr(input logic [15:0] idx);
        byteAddr = {idx, 2'b00};
    endfunction
endpackage

// >>> gain_scaler.sv
`timescale 1ns/1ps
module gain_scaler #(
    parameter int SW = 24,
    parameter int OW = 30
) (
    input  wire logic signed [SW-1:0] sampleIn,
    input  wire logic [2:0]           gainExp,
    input  wire logic                 gainNegative,
    input  wire logic                 quarterGain,
    output logic signed [OW-1:0]      sampleOut
);
    if (OW < SW + metering_ctrl_pkg::GAIN_HEADROOM) begin : g_chk
        $error("gain_scaler output too narrow");
    end

    logic signed [OW-1:0] extended;
    logic signed [OW-1:0] shifted;
    logic [2:0]           expUsed;

    always_comb begin
        // Codes above the maximum saturate so the result stays defined
        expUsed  = (gainExp > metering_ctrl_pkg::GAIN_EXP_MAX)
                 ? metering_ctrl_pkg::GAIN_EXP_MAX : gainExp; // RQ13
        extended = OW'(sampleIn);
        shifted  = extended <<< expUsed; // RQ10 RQ11
        if (quarterGain) begin
            shifted = shifted >>> metering_ctrl_pkg::QUARTER_SHIFT; // RQ12
        end
        sampleOut = gainNegative ? -shifted : shifted;
    end
endmodule // gain_scaler

// >>> sample_fifo.sv
`timescale 1ns/1ps
module sample_fifo #(
    parameter int WIDTH = 120,
    parameter int DEPTH = 16
) (
    input  wire logic             core_clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] inData,
    input  wire logic             inValid,
    output logic                  inReady,
    output logic [WIDTH-1:0]      outData,
    output logic                  outValid,
    input  wire logic             outReady,
    output logic [$clog2(DEPTH):0] level
);
    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
        $error("sample_fifo depth must be a power of two");
    end

    typedef struct packed {
        logic [AW-1:0] wrPtr;
        logic [AW-1:0] rdPtr;
        logic [AW:0]   count;
    } fifo_state_s;

    fifo_state_s     st;
    fifo_state_s     next_st;
    logic [WIDTH-1:0] mem [DEPTH];
    logic            push;
    logic            pop;

    assign inReady  = (st.count != (AW+1)'(DEPTH));
    assign outValid = (st.count != '0);
    assign push     = inValid && inReady;
    assign pop      = outValid && outReady;
    assign outData  = mem[st.rdPtr];
    assign level    = st.count;

    always_comb begin
        next_st = st;
        if (push) begin
            next_st.wrPtr = st.wrPtr + AW'(1);
        end
        if (pop) begin
            next_st.rdPtr = st.rdPtr + AW'(1);
        end
        next_st.count = st.count + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // Storage needs no reset; only the pointers and count define what is valid
    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[st.wrPtr] <= inData;
        end
    end
endmodule // sample_fifo

// >>> metering_ctrl_sva.sv
`timescale 1ns/1ps
module metering_ctrl_sva #(
    parameter int SW    = 24,
    parameter int DEPTH = 16
) (
    input wire logic        core_clk,
    input wire logic        rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [17:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        sampleValid,
    input wire logic        sampleReady,
    input wire logic [SW+5:0] voltageOut,
    input wire logic        outValid,
    input wire logic        outReady,
    input wire logic        phaseCompVoltCurOne,
    input wire logic        phaseCompVoltCurTwo,
    input wire logic        calcRun,
    input wire logic        engineResultWrite,
    input wire logic        resultWriteEnable
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    // Mirror of the block bit, taken from completed writes to the channel register
    logic blockSeen;
    always_ff @(posedge core_clk) begin
        if (rst) begin
            blockSeen <= 1'b0;
        end else if (psel && penable && pwrite && paddr == 18'h0A1E0) begin
            blockSeen <= pwdata[7];
        end
    end
    sequence chWrS; psel && penable && pwrite && paddr == 18'h0A1E0; endsequence
    sequence takeS; sampleValid && sampleReady && !outValid; endsequence
    sequence allowS; engineResultWrite && calcRun && !blockSeen; endsequence
    unmapped_err_a: assert property (psel && penable && !(paddr inside {18'h0A1E0, 18'h0A1E4,
        18'h0A1E8, 18'h0A280}) |-> pslverr) else $error("unmapped access not refused");
    result_block_a: assert property (blockSeen |-> !resultWriteEnable)
        else $error("result write not blocked");
    result_pass_a: assert property (allowS |-> resultWriteEnable)
        else $error("result write wrongly held off");
    apb_ready_a: assert property (psel && penable |-> pready) else $error("access not answered");
    apb_mapped_a: assert property (psel && penable && (paddr == 18'h0A1E0 || paddr == 18'h0A1E4)
        |-> !pslverr) else $error("error on mapped register");
    calc_write_a: assert property (chWrS |=> calcRun == $past(pwdata[4]))
        else $error("calc enable not taken from write");
    phase_write_a: assert property (chWrS |=> phaseCompVoltCurOne == $past(pwdata[6]))
        else $error("phase enable not taken from write");
    phase_pair_a: assert property (phaseCompVoltCurOne == phaseCompVoltCurTwo)
        else $error("phase outputs differ");
    result_gate_a: assert property (resultWriteEnable |-> engineResultWrite && calcRun)
        else $error("result write not gated");
    reset_clear_a: assert property ($fell(rst) |-> !calcRun && !outValid && !phaseCompVoltCurOne)
        else $error("state not cleared by reset");
    out_hold_a: assert property (outValid && !outReady |=> outValid && $stable(voltageOut))
        else $error("output changed while stalled");
    take_latency_a: assert property (takeS |-> ##[1:2] outValid) else $error("sample not delivered");
    full_refuse_a: assert property (!sampleReady |-> outValid) else $error("refused while empty");
endmodule // metering_ctrl_sva

bind metering_channel_control metering_ctrl_sva #(
    .SW    (SW),
    .DEPTH (DEPTH)
) checker_i (
    .core_clk            (core_clk),
    .rst                 (rst),
    .psel                (psel),
    .penable             (penable),
    .pwrite              (pwrite),
    .paddr               (paddr),
    .pwdata              (pwdata),
    .pready              (pready),
    .pslverr             (pslverr),
    .sampleValid         (sampleValid),
    .sampleReady         (sampleReady),
    .voltageOut          (voltageOut),
    .outValid            (outValid),
    .outReady            (outReady),
    .phaseCompVoltCurOne (phaseCompVoltCurOne),
    .phaseCompVoltCurTwo (phaseCompVoltCurTwo),
    .calcRun             (calcRun),
    .engineResultWrite   (engineResultWrite),
    .resultWriteEnable   (resultWriteEnable)
);

// >>> result_sink.sv
`timescale 1ns/1ps
module result_sink (
    input  wire logic core_clk,
    input  wire logic rst,
    input  wire logic stall,
    output logic      outReady,
    output logic      engineResultWrite
);
    // Engine asks to write every other cycle, so gating is seen both ways
    always_ff @(posedge core_clk) begin
        if (rst) engineResultWrite <= 1'b0;
        else engineResultWrite <= ~engineResultWrite;
    end
    assign outReady = ~stall;
endmodule // result_sink

// >>> tb.sv
`timescale 1ns/1ps
module tb;
    localparam logic [17:0] CH = 18'h0A1E0, GN = 18'h0A1E4, TH = 18'h0A1E8;
    localparam logic [17:0] ST = 18'h0A280, UN = 18'h0A1F0;
    logic core_clk, rst, psel, penable, pwrite, pready, pslverr, stall;
    logic [17:0] paddr;
    logic [31:0] pwdata, prdata, rv;
    logic ev;
    logic signed [23:0] voltageSample, currentASample, currentBSample, multiSample;
    logic signed [29:0] voltageOut, currentOneOut, currentTwoOut, multiOut;
    logic sampleValid, sampleReady, outValid, outReady;
    logic phaseCompVoltCurOne, phaseCompVoltCurTwo, calcRun, engineResultWrite, resultWriteEnable;
    int failures, samples_checked, k, n;

    metering_channel_control dut (.core_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .voltageSample, .currentASample, .currentBSample,
        .multiSample, .sampleValid, .sampleReady, .voltageOut, .currentOneOut, .currentTwoOut,
        .multiOut, .outValid, .outReady, .phaseCompVoltCurOne, .phaseCompVoltCurTwo, .calcRun,
        .engineResultWrite, .resultWriteEnable);
    result_sink sink (.core_clk, .rst, .stall, .outReady, .engineResultWrite);

    initial begin
        core_clk = 0;
        forever #5 core_clk = ~core_clk;
    end

    task automatic summarize();
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic apb(input logic w, input logic [17:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int i;
        @(posedge core_clk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge core_clk);
        penable <= 1;
        // Answer and read data are taken at the edge that samples pready high
        for (i = 0; i < 20; i++) begin
            @(posedge core_clk);
            if (pready === 1'b1) break;
        end
        r = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
        if (i == 20) begin failures++; summarize(); end
    endtask

    task automatic wr(logic [17:0] a, logic [31:0] d);
        apb(1, a, d, rv, ev);
    endtask

    task automatic rchk(string nm, logic [17:0] a, logic [31:0] e);
        apb(0, a, 32'h0, rv, ev);
        chk(nm, e, rv);
    endtask

    task automatic push(logic signed [23:0] v, a, b, m);
        int i;
        @(posedge core_clk);
        sampleValid <= 1; voltageSample <= v; currentASample <= a;
        currentBSample <= b; multiSample <= m;
        for (i = 0; i < 50; i++) begin
            @(posedge core_clk);
            if (sampleReady === 1'b1) break;
        end
        sampleValid <= 0;
        if (i == 50) begin failures++; summarize(); end
    endtask

    function automatic logic signed [29:0] scl(logic signed [23:0] x, logic [2:0] e, logic s, q);
        logic signed [29:0] y;
        y = x;
        y = y <<< (e > 3'h5 ? 3'h5 : e);
        if (q) y = y >>> 2;
        scl = s ? -y : y;
    endfunction

    task automatic runCase(logic [7:0] c, g, logic q, logic signed [23:0] v, a, b, m);
        int i;
        logic signed [23:0] one, two;
        one = c[5] ? b : a;
        two = c[5] ? a : b;
        wr(CH, {24'h0, c}); wr(GN, {24'h0, g}); wr(TH, {26'h0, q, 5'h0});
        push(v, a, b, m);
        for (i = 0; i < 50 && outValid !== 1'b1; i++) @(negedge core_clk);
        if (i == 50) begin failures++; summarize(); end
        chk("volt", scl(c[0] ? v : 24'sh0, g[2:0], g[3], q), voltageOut);
        chk("cur1", scl(c[1] ? one : 24'sh0, g[6:4], g[7], 0), currentOneOut);
        chk("cur2", scl(c[2] ? two : 24'sh0, 0, 0, 0), currentTwoOut);
        chk("multi", scl(c[3] & c[4] ? m : 24'sh0, 0, 0, 0), multiOut);
        chk("calc", c[4], calcRun);
        chk("rwe", engineResultWrite & c[4] & ~c[7], resultWriteEnable);
        chk("phase", c[6], phaseCompVoltCurTwo);
        chk("phase1", c[6], phaseCompVoltCurOne);
        // Engine strobe toggles; look again one cycle later for the other phase
        @(negedge core_clk);
        chk("rwe2", engineResultWrite & c[4] & ~c[7], resultWriteEnable);
    endtask

    initial begin
        rst = 1; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; stall = 0;
        sampleValid = 0; voltageSample = 0; currentASample = 0; currentBSample = 0;
        multiSample = 0; failures = 0; samples_checked = 0;
        repeat (12) @(posedge core_clk);
        rst <= 0;
        rchk("ch0", CH, 32'h0);
        rchk("gn0", GN, 32'h0);
        rchk("th0", TH, 32'h0);
        wr(CH, 32'hFF); rchk("chrw", CH, 32'hFF);
        wr(GN, 32'hA5); rchk("gnrw", GN, 32'hA5);
        wr(TH, 32'h20); rchk("thrw", TH, 32'h20);
        apb(1, UN, 32'hFF, rv, ev); chk("unw", 1, ev);
        apb(0, UN, 32'h0, rv, ev); chk("unr", 0, rv);
        runCase(8'h00, 8'h00, 0, 24'sh012345, 24'shFFFCDF, 24'sh000456, 24'sh000789);
        runCase(8'h1F, 8'h00, 0, 24'sh012345, 24'shFFFCDF, 24'sh000456, 24'sh000789);
        runCase(8'h7F, 8'h25, 0, 24'sh012345, 24'shFFFCDF, 24'sh000456, 24'sh000789);
        runCase(8'h17, 8'hBF, 1, 24'sh00F0F1, 24'sh001234, 24'shFF0001, 24'sh000777);
        runCase(8'h8F, 8'h0E, 1, 24'shFFF123, 24'sh000321, 24'sh000654, 24'sh000777);
        runCase(8'h9F, 8'h5A, 0, 24'sh000111, 24'sh000222, 24'sh000333, 24'sh000444);
        // Fill with consumer stalled: 16 FIFO words plus the stage
        @(posedge core_clk);
        stall <= 1;
        for (k = 0; k < 17; k++) push(24'(k), 24'(k), 24'(k), 24'(k));
        @(negedge core_clk);
        chk("full", 0, sampleReady);
        rchk("level", ST, 32'd16);
        @(posedge core_clk);
        stall <= 0;
        n = 0;
        repeat (40) begin
            @(negedge core_clk);
            if (outValid === 1'b1 && outReady === 1'b1) begin
                chk("order", 32'(n), multiOut);
                n++;
            end
        end
        chk("drain", 17, n);
        chk("empty", 0, outValid);
        wr(CH, 32'h5A);
        @(posedge core_clk);
        rst <= 1;
        @(posedge core_clk);
        rst <= 0;
        rchk("chrst", CH, 32'h0);
        summarize();
    end
endmodule // tb
